// ---- rtl/edge_if.sv ----
// interface: edge events from a pin sampler to the timer logic
`timescale 1ns/10ps
`default_nettype none
interface edge_if;
  logic fall;
  logic rise;
  modport src (output fall, output rise);
  modport dst (input fall, input rise);
endinterface
`default_nettype wire

// ---- rtl/pin_sampler.sv ----
// module: samples a timer clock pin on phase strobes and reports edges
`timescale 1ns/10ps
`default_nettype none
module pin_sampler (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sample_en,
  input  wire logic pin,
  edge_if.src       ev
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 is seen only by stage2; edges come from stage2 against stage3
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (sample_en) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // gated by the strobe so one edge yields exactly one pulse
  assign ev.fall = sample_en & stage3 & ~stage2;
  assign ev.rise = sample_en & ~stage3 & stage2;

  AST_ONE_PULSE_PER_EDGE: assert property (
    @(posedge clk) disable iff (!rst_n)
    ev.fall |=> !ev.fall ##1 !ev.fall)
    else $error("fall pulse repeated within one sample period");
endmodule
`default_nettype wire

// ---- rtl/timer_bank.sv ----
// module: four timer/counters behind an AXI4-Lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module timer_bank
  import timer_bank_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              t0_clock_pin,
  input  wire logic              shared_ext_clock_pin,
  input  wire logic              timer_c_ext_clock_pin,
  input  wire logic              capture2_strobe,
  output logic [3:0]             rollover_flags,
  output logic [7:0]             pwm_base_a,
  output logic [7:0]             pwm_base_b,
  output logic [15:0]            capture_base
);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [7:0] ps_limit(input logic [3:0] sel);
    ps_limit = (sel >= PS_MAX_SEL) ? 8'hFF
             : 8'((16'h0001 << sel) - 16'h0001);
  endfunction

  // ---------------- registers ----------------
  logic [T0_CTRL_W-1:0] first_timer_control;
  logic [15:0]          prescaled_overflow_counter;
  logic [7:0]           timer_a_count;
  logic [7:0]           timer_b_count;
  logic [7:0]           timer_a_period;
  logic [7:0]           timer_b_period;
  logic [7:0]           timer_ctrl;
  logic [15:0]          timer_c_count;
  logic [15:0]          timer_c_period;
  logic [3:0]           flags;

  // ---------------- bus slave ----------------
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_fire;
  logic              rd_fire;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held;
  assign rd_fire = arvalid && arready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held  <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  wire w_t0_ctrl  = wr_fire && wr_addr == OFS_T0_CTRL;
  wire w_t0_count = wr_fire && wr_addr == OFS_T0_COUNT;
  wire w_a_count  = wr_fire && wr_addr == OFS_A_COUNT;
  wire w_b_count  = wr_fire && wr_addr == OFS_B_COUNT;
  wire w_a_period = wr_fire && wr_addr == OFS_A_PERIOD;
  wire w_b_period = wr_fire && wr_addr == OFS_B_PERIOD;
  wire w_tctrl    = wr_fire && wr_addr == OFS_TIMER_CTRL;
  wire w_c_count  = wr_fire && wr_addr == OFS_C_COUNT;
  wire w_c_period = wr_fire && wr_addr == OFS_C_PERIOD;
  wire w_flags    = wr_fire && wr_addr == OFS_FLAGS;
  wire wr_mapped  = w_t0_ctrl | w_t0_count | w_a_count | w_b_count
                  | w_a_period | w_b_period | w_tctrl | w_c_count
                  | w_c_period | w_flags;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read decode: and-or of the selected register
  wire r_t0c = araddr == OFS_T0_CTRL;
  wire r_t0n = araddr == OFS_T0_COUNT;
  wire r_ac  = araddr == OFS_A_COUNT;
  wire r_bc  = araddr == OFS_B_COUNT;
  wire r_ap  = araddr == OFS_A_PERIOD;
  wire r_bp  = araddr == OFS_B_PERIOD;
  wire r_tc  = araddr == OFS_TIMER_CTRL;
  wire r_cc  = araddr == OFS_C_COUNT;
  wire r_cp  = araddr == OFS_C_PERIOD;
  wire r_fl  = araddr == OFS_FLAGS;
  wire rd_mapped = r_t0c | r_t0n | r_ac | r_bc | r_ap | r_bp | r_tc
                 | r_cc | r_cp | r_fl;
  wire [31:0] rd_word =
      ({32{r_t0c}} & {25'h0, first_timer_control})
    | ({32{r_t0n}} & {16'h0, prescaled_overflow_counter})
    | ({32{r_ac}}  & {24'h0, timer_a_count})
    | ({32{r_bc}}  & {24'h0, timer_b_count})
    | ({32{r_ap}}  & {24'h0, timer_a_period})
    | ({32{r_bp}}  & {24'h0, timer_b_period})
    | ({32{r_tc}}  & {24'h0, timer_ctrl})
    | ({32{r_cc}}  & {16'h0, timer_c_count})
    | ({32{r_cp}}  & {16'h0, timer_c_period})
    | ({32{r_fl}}  & {28'h0, flags});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- time base ----------------
  logic [1:0] phase;
  wire inst_tick = phase == INST_LAST_PHASE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  edge_if shared_ev ();
  edge_if c_ev ();

  // phase[0] gives two sample strobes per instruction cycle
  pin_sampler shared_sampler (
    .clk       (clk),
    .rst_n     (rst_n),
    .sample_en (phase[0]),
    .pin       (shared_ext_clock_pin),
    .ev        (shared_ev.src)
  );

  pin_sampler c_sampler (
    .clk       (clk),
    .rst_n     (rst_n),
    .sample_en (phase[0]),
    .pin       (timer_c_ext_clock_pin),
    .ev        (c_ev.src)
  );

  // ---------------- first timer ----------------
  wire       t0_run  = first_timer_control[T0_RUN_BIT];
  wire       t0_ext  = first_timer_control[T0_EXT_BIT];
  wire       t0_rise = first_timer_control[T0_RISE_BIT];
  wire [3:0] prescale_select = first_timer_control[T0_PS_LSB +: 4];
  logic       t0_pin_d;
  logic [7:0] ps_cnt;
  logic       ps_toggle;
  logic       ps_s1;
  logic       ps_s2;
  logic       ps_s3;

  wire t0_edge = t0_rise ? (t0_clock_pin & ~t0_pin_d)
                         : (~t0_clock_pin & t0_pin_d);
  wire t0_src_evt = t0_run && (t0_ext ? t0_edge : inst_tick);
  wire ps_hit     = ps_cnt == ps_limit(prescale_select);
  // prescaler output crosses as a toggle, so fast pin edges stay countable
  wire t0_tick    = ps_s2 ^ ps_s3;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t0_pin_d  <= 1'b0;
      ps_cnt    <= 8'h00;
      ps_toggle <= 1'b0;
      ps_s1     <= 1'b0;
      ps_s2     <= 1'b0;
      ps_s3     <= 1'b0;
    end else begin
      t0_pin_d <= t0_clock_pin;
      ps_s1    <= ps_toggle;
      ps_s2    <= ps_s1;
      ps_s3    <= ps_s2;
      if (w_t0_ctrl) begin
        ps_cnt <= 8'h00;
      end else if (t0_src_evt) begin
        ps_cnt    <= ps_hit ? 8'h00 : ps_cnt + 8'h01;
        ps_toggle <= ps_toggle ^ ps_hit;
      end
    end
  end

  wire t0_inc  = t0_tick && t0_run;
  wire t0_wrap = t0_inc && prescaled_overflow_counter == 16'hFFFF;
  wire [15:0] next_t0_count =
      w_t0_count ? merge16(prescaled_overflow_counter, wr_data, wr_strb)
    : t0_inc     ? prescaled_overflow_counter + 16'h0001
    : prescaled_overflow_counter;

  // ---------------- timers A and B ----------------
  wire a_cs  = timer_ctrl[A_CS_BIT];
  wire b_cs  = timer_ctrl[B_CS_BIT];
  wire join_sel = timer_ctrl[JOIN_BIT];
  wire a_run = timer_ctrl[A_RUN_BIT];
  wire b_run = timer_ctrl[B_RUN_BIT];

  wire a_src = a_cs ? shared_ev.fall : inst_tick;
  wire b_src = b_cs ? shared_ev.fall : inst_tick;
  wire join_tick = join_sel && a_run && b_run && a_src;
  // joined with B stopped, A keeps counting on its own
  wire a_tick = a_run && a_src && !(join_sel && b_run);
  wire b_tick = !join_sel && b_run && b_src;

  wire [15:0] joined_count  = {timer_b_count, timer_a_count};
  wire [15:0] joined_period = {timer_b_period, timer_a_period};
  wire join_match = joined_count == joined_period;
  wire a_match    = timer_a_count == timer_a_period;
  wire b_match    = timer_b_count == timer_b_period;
  wire [15:0] joined_next = join_match ? 16'h0000
                          : joined_count + 16'h0001;

  wire [15:0] a_wr_word = merge16({8'h00, timer_a_count}, wr_data, wr_strb);
  wire [15:0] b_wr_word = merge16({8'h00, timer_b_count}, wr_data, wr_strb);
  wire [7:0] next_a_count =
      w_a_count ? a_wr_word[7:0]
    : join_tick ? joined_next[7:0]
    : a_tick    ? (a_match ? 8'h00 : timer_a_count + 8'h01)
    : timer_a_count;
  wire [7:0] next_b_count =
      w_b_count ? b_wr_word[7:0]
    : join_tick ? joined_next[15:8]
    : b_tick    ? (b_match ? 8'h00 : timer_b_count + 8'h01)
    : timer_b_count;

  // ---------------- timer C ----------------
  wire c_run  = timer_ctrl[C_RUN_BIT];
  wire c_dual = timer_ctrl[DUAL_BIT];
  wire c_src  = timer_ctrl[C_CS_BIT] ? c_ev.fall : inst_tick;
  wire c_tick = c_run && c_src;
  // in dual capture the period is a capture register, so count freely
  wire [15:0] c_limit = c_dual ? 16'hFFFF : timer_c_period;
  wire c_match   = timer_c_count == c_limit;
  wire c_capture = c_dual && capture2_strobe;

  wire [15:0] next_c_count =
      w_c_count ? merge16(timer_c_count, wr_data, wr_strb)
    : c_tick    ? (c_match ? 16'h0000 : timer_c_count + 16'h0001)
    : timer_c_count;
  // a capture beats a simultaneous software write
  wire [15:0] next_c_period =
      c_capture  ? timer_c_count
    : w_c_period ? merge16(timer_c_period, wr_data, wr_strb)
    : timer_c_period;

  // ---------------- rollover flags ----------------
  wire [3:0] flag_set;
  assign flag_set[F_T0] = t0_wrap;
  assign flag_set[F_A]  = (join_tick && join_match)
                        || (a_tick && a_match);
  assign flag_set[F_B]  = b_tick && b_match;
  assign flag_set[F_C]  = c_tick && c_match;
  wire [3:0] flag_clr   = (w_flags && wr_strb[0]) ? wr_data[3:0] : 4'h0;
  // set wins over a clear in the same cycle
  wire [3:0] next_flags = (flags & ~flag_clr) | flag_set;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_timer_control        <= T0_CTRL_RST;
      prescaled_overflow_counter <= COUNT_RST;
      timer_a_count              <= COUNT_RST[7:0];
      timer_b_count              <= COUNT_RST[7:0];
      timer_a_period             <= PERIOD8_RST;
      timer_b_period             <= PERIOD8_RST;
      timer_ctrl                 <= TIMER_CTRL_RST;
      timer_c_count              <= COUNT_RST;
      timer_c_period             <= PERIOD16_RST;
      flags                      <= FLAGS_RST;
    end else begin
      if (w_t0_ctrl && wr_strb[0]) begin
        first_timer_control <= wr_data[T0_CTRL_W-1:0];
      end
      if (w_a_period && wr_strb[0]) begin
        timer_a_period <= wr_data[7:0];
      end
      if (w_b_period && wr_strb[0]) begin
        timer_b_period <= wr_data[7:0];
      end
      if (w_tctrl && wr_strb[0]) begin
        timer_ctrl <= wr_data[7:0];
      end
      prescaled_overflow_counter <= next_t0_count;
      timer_a_count              <= next_a_count;
      timer_b_count              <= next_b_count;
      timer_c_count              <= next_c_count;
      timer_c_period             <= next_c_period;
      flags                      <= next_flags;
    end
  end

  assign rollover_flags = flags;
  assign pwm_base_a     = timer_a_count;
  assign pwm_base_b     = timer_b_count;
  assign capture_base   = timer_c_count;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_T0_OVERFLOW: assert property (
    t0_wrap && !w_t0_count |=>
      prescaled_overflow_counter == 16'h0000 && flags[F_T0])
    else $error("first timer overflow did not wrap and flag");
  AST_PS_TERMINAL: assert property (
    $changed(ps_toggle) |-> $past(ps_hit) && $past(t0_src_evt))
    else $error("prescaler output without terminal count");
  AST_EDGE_POLARITY: assert property (
    t0_run && t0_ext && !t0_rise && t0_clock_pin && !t0_pin_d
      |-> !t0_src_evt)
    else $error("rising edge counted while falling edge selected");
  AST_SYNC_DELAY: assert property (
    t0_src_evt && ps_hit && !w_t0_ctrl |-> ##3 t0_tick)
    else $error("prescaler output not seen three cycles later");
  AST_A_ROLLOVER: assert property (
    a_tick && a_match && !w_a_count |=> timer_a_count == 8'h00
      && flags[F_A])
    else $error("timer A did not roll over at its period");
  AST_B_ROLLOVER: assert property (
    b_tick && b_match && !w_b_count |=> timer_b_count == 8'h00
      && flags[F_B])
    else $error("timer B did not roll over at its period");
  AST_JOIN_ROLLOVER: assert property (
    join_tick && join_match && !w_a_count && !w_b_count
      |=> joined_count == 16'h0000 && flags[F_A])
    else $error("joined timer did not reload zero at its period");
  AST_JOIN_STOPPED: assert property (
    join_sel && !a_run && !w_a_count && !w_b_count
      |=> $stable(joined_count))
    else $error("joined timer moved with timer A stopped");
  AST_JOIN_STEP: assert property (
    join_tick && !join_match && !w_a_count && !w_b_count
      |=> joined_count == $past(joined_count) + 16'h0001)
    else $error("joined timer did not advance by one");
  AST_FLAG_STICKY: assert property (
    flags[F_A] && !(w_flags && wr_strb[0] && wr_data[F_A])
      |=> flags[F_A])
    else $error("timer A flag fell without a software clear");
  AST_C_CAPTURE: assert property (
    c_capture |=> timer_c_period == $past(timer_c_count))
    else $error("dual capture did not load timer C count");

  COV_JOIN_ROLL: cover property (join_tick && join_match);
  COV_T0_WRAP: cover property (t0_wrap);
  COV_C_CAPTURE: cover property (c_capture ##1 c_tick);
  COV_FLAG_RACE: cover property (w_flags && |(flag_set & wr_data[3:0]));
endmodule
`default_nettype wire

// ---- rtl/timer_bank_pkg.sv ----
// package: register map, field positions, reset values and timing counts
package timer_bank_pkg;
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  OFS_T0_CTRL     = 6'h00;
  localparam logic [5:0]  OFS_T0_COUNT    = 6'h04;
  localparam logic [5:0]  OFS_A_COUNT     = 6'h08;
  localparam logic [5:0]  OFS_B_COUNT     = 6'h0C;
  localparam logic [5:0]  OFS_A_PERIOD    = 6'h10;
  localparam logic [5:0]  OFS_B_PERIOD    = 6'h14;
  localparam logic [5:0]  OFS_TIMER_CTRL  = 6'h18;
  localparam logic [5:0]  OFS_C_COUNT     = 6'h1C;
  localparam logic [5:0]  OFS_C_PERIOD    = 6'h20;
  localparam logic [5:0]  OFS_FLAGS       = 6'h24;
  // first_timer_control fields
  localparam int          T0_RUN_BIT      = 0;
  localparam int          T0_PS_LSB       = 1;
  localparam int          T0_EXT_BIT      = 5;
  localparam int          T0_RISE_BIT     = 6;
  localparam int          T0_CTRL_W       = 7;
  // timer_ctrl fields
  localparam int          A_CS_BIT        = 0;
  localparam int          B_CS_BIT        = 1;
  localparam int          C_CS_BIT        = 2;
  localparam int          JOIN_BIT        = 3;
  localparam int          A_RUN_BIT       = 4;
  localparam int          B_RUN_BIT       = 5;
  localparam int          C_RUN_BIT       = 6;
  localparam int          DUAL_BIT        = 7;
  // rollover flag positions
  localparam int          F_T0            = 0;
  localparam int          F_A             = 1;
  localparam int          F_B             = 2;
  localparam int          F_C             = 3;
  // reset values
  localparam logic [6:0]  T0_CTRL_RST     = 7'h00;
  localparam logic [7:0]  TIMER_CTRL_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST       = 16'h0000;
  localparam logic [7:0]  PERIOD8_RST     = 8'hFF;
  localparam logic [15:0] PERIOD16_RST    = 16'hFFFF;
  localparam logic [3:0]  FLAGS_RST       = 4'h0;
  // timing: instruction cycle is oscillator/4, pin sampled twice per cycle
  localparam logic [1:0]  INST_LAST_PHASE = 2'h3;
  localparam logic [3:0]  PS_MAX_SEL      = 4'h8;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ---- tb/ext_clock_source.sv ----
// model: external clock source driving one timer clock pin
`timescale 1ns/10ps
`default_nettype none
module ext_clock_source (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            pin
);
  logic [3:0] cnt;
  // idles high between bursts so a stopped source never makes a fall
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= 4'h0;
      pin <= 1'b1;
    end else if (cnt == half - 4'h1) begin
      cnt <= 4'h0;
      pin <= !pin;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_timer_bank.sv ----
// bench: register-level scenarios for the four-timer bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module test_timer_bank;
  import timer_bank_pkg::*;
  localparam logic [31:0] M_J = 32'h1 << JOIN_BIT;
  localparam logic [31:0] M_A = 32'h1 << A_RUN_BIT;
  localparam logic [31:0] M_B = 32'h1 << B_RUN_BIT;
  localparam logic [31:0] M_C = 32'h1 << C_RUN_BIT;
  localparam logic [31:0] M_X = 32'h1 << A_CS_BIT | 32'h1 << C_CS_BIT;
  localparam logic [31:0] M_D = 32'h1 << DUAL_BIT;
  localparam logic [31:0] M_TX = 32'h1 << T0_RUN_BIT | 32'h1 << T0_EXT_BIT;
  localparam logic [31:0] M_TR = M_TX | 32'h1 << T0_RISE_BIT;
  logic              clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, cap;
  logic              run_s, run_c, pin_s, pin_c, pin_t;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb, flags;
  logic [1:0]        bresp, rresp, r, b;
  logic [7:0]        pa, pb;
  logic [15:0]       pc;
  int                fail_count = 0;
  int                tests_run = 0;
  timer_bank u_dut (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .t0_clock_pin(pin_t), .shared_ext_clock_pin(pin_s),
    .timer_c_ext_clock_pin(pin_c), .capture2_strobe(cap),
    .rollover_flags(flags), .pwm_base_a(pa), .pwm_base_b(pb),
    .capture_base(pc));
  ext_clock_source u_src_s (.clk(clk), .rst_n(rst_n), .run(run_s),
    .half(4'h6), .pin(pin_s));
  ext_clock_source u_src_c (.clk(clk), .rst_n(rst_n), .run(run_c),
    .half(4'h6), .pin(pin_c));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // each call first lets an edge pass, so a strobe lowered by the last
  // call is never raised again in the same time step
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic ta = 1'b0, tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ta || !tw) begin
      @(posedge clk);
      if (!ta && awready) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (!tw && wready) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end
    do @(posedge clk); while (!bvalid);
    b = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_reset;
    rd(OFS_A_PERIOD);
    `CHK(d, 32'h0000_00FF)
    rd(OFS_C_PERIOD);
    `CHK(d, 32'h0000_FFFF)
    rd(6'h3C);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(6'h3C, 32'h1);
    `CHK(b, RESP_SLVERR)
  endtask
  task automatic t_split;
    wr(OFS_A_PERIOD, 32'h2);
    wr(OFS_B_PERIOD, 32'h5);
    wr(OFS_C_PERIOD, 32'h3);
    wr(OFS_TIMER_CTRL, M_A | M_B | M_C);
    repeat (60) @(posedge clk);
    `CHK(flags[F_C:F_A], 3'h7)
    `CHK(pa <= 8'h2 && pb <= 8'h5 && pc <= 16'h3, 1'b1)
    wr(OFS_TIMER_CTRL, 32'h0);
    wr(OFS_FLAGS, 32'hF);
    rd(OFS_B_COUNT);
    repeat (30) @(posedge clk);
    `CHK({24'h0, pb}, d)
    `CHK(flags, FLAGS_RST)
  endtask
  task automatic t_join;
    int n = 0;
    wr(OFS_B_PERIOD, 32'h1);
    wr(OFS_B_COUNT, 32'h0);
    wr(OFS_TIMER_CTRL, M_J | M_A);
    repeat (60) @(posedge clk);
    `CHK({flags[F_A], pb}, 9'h100)
    wr(OFS_TIMER_CTRL, 32'h0);
    wr(OFS_FLAGS, 32'hF);
    wr(OFS_A_COUNT, 32'h0);
    wr(OFS_TIMER_CTRL, M_J | M_A | M_B);
    while (flags[F_A] !== 1'b1 && n < 1200) begin
      @(negedge clk);
      n++;
    end
    // 0x0102 matches after 0x103 ticks of four clocks each
    `CHK(n >= 1024 && n <= 1048, 1'b1)
    `CHK({flags[F_B], pb}, 9'h000)
  endtask
  task automatic t_ext;
    wr(OFS_TIMER_CTRL, M_D);
    wr(OFS_A_COUNT, 32'h0);
    wr(OFS_B_COUNT, 32'h0);
    wr(OFS_C_COUNT, 32'h0);
    wr(OFS_TIMER_CTRL, M_J | M_A | M_B | M_C | M_X | M_D);
    run_s <= 1'b1;
    run_c <= 1'b1;
    repeat (110) @(posedge clk);
    run_s <= 1'b0;
    run_c <= 1'b0;
    repeat (14) @(posedge clk);
    `CHK({pb, pa}, 16'h0009)
    `CHK(pc, 16'h0009)
    wr(OFS_TIMER_CTRL, M_D);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    rd(OFS_C_PERIOD);
    `CHK(d, 32'h0000_0009)
  endtask
  task automatic t_pre;
    wr(OFS_T0_CTRL, 32'h1 << T0_RUN_BIT | 32'h2 << T0_PS_LSB);
    repeat (800) @(posedge clk);
    rd(OFS_T0_COUNT);
    `CHK(d >= 32'd46 && d <= 32'd51, 1'b1)
  endtask
  task automatic t_t0ext;
    wr(OFS_T0_CTRL, M_TX);
    wr(OFS_T0_COUNT, 32'h0);
    repeat (3) begin
      pin_t <= 1'b0;
      repeat (8) @(posedge clk);
      pin_t <= 1'b1;
      repeat (8) @(posedge clk);
    end
    rd(OFS_T0_COUNT);
    `CHK(d, 32'h3)
    wr(OFS_T0_CTRL, M_TR);
    pin_t <= 1'b0;
    repeat (8) @(posedge clk);
    rd(OFS_T0_COUNT);
    `CHK(d, 32'h3)
    pin_t <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFS_T0_COUNT);
    `CHK(d, 32'h4)
    wr(OFS_T0_COUNT, 32'hFFFF);
    pin_t <= 1'b0;
    repeat (8) @(posedge clk);
    pin_t <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFS_T0_COUNT);
    `CHK({flags[F_T0], d}, {1'b1, 32'h0})
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {cap, run_s, run_c, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    pin_t = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_split();
    t_join();
    t_ext();
    t_pre();
    t_t0ext();
    print_verdict();
  end
  initial begin
    repeat (10000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
